// ---- inc/tpm_params.svh ----
// Purpose: offsets, read values, pwm periods, reset values for the timer pair block
// Assumes: byte-wide registers on a plain register port
// Notes:   definitions only
`ifndef TPM_PARAMS_SVH
`define TPM_PARAMS_SVH

`define TPM_ADDR_W          9
`define TPM_A_LOW_CMP       9'h102
`define TPM_A_HIGH_CMP      9'h103
`define TPM_A_MODE_CFG      9'h104
`define TPM_A_FF_CTRL       9'h105
`define TPM_B_LOW_CMP       9'h112
`define TPM_B_HIGH_CMP      9'h113
`define TPM_B_MODE_CFG      9'h114
`define TPM_B_FF_CTRL       9'h115
`define TPM_CMP_RESET       8'h00
`define TPM_MODE_RESET      8'h00
`define TPM_FF_CMD_RESET    2'h3
`define TPM_FF_UNUSED_READ  4'hf
`define TPM_UNDEF_READ      8'h00
`define TPM_PWM_P6          9'h040
`define TPM_PWM_P7          9'h080
`define TPM_PWM_P8          9'h100

`endif

// ---- inc/tpm_pkg.sv ----
// Purpose: types for the timer pair mode and output flip-flop block
// Assumes: used with tpm_params.svh
// Notes:   mode and command encodings follow the register fields
package tpm_pkg;

    typedef enum logic [1:0] {
        TPM_MODE_TWO8,
        TPM_MODE_CASC16,
        TPM_MODE_PPG,
        TPM_MODE_PWM
    } tpm_mode_t;

    typedef enum logic [1:0] {
        TPM_FF_INVERT,
        TPM_FF_SET,
        TPM_FF_CLEAR,
        TPM_FF_HOLD
    } tpm_ff_cmd_t;

    // mode register layout
    typedef struct packed {
        tpm_mode_t  mode;
        logic [1:0] pwm_period;
        logic [1:0] upper_clk;
        logic [1:0] lower_clk;
    } tpm_mode_cfg_t;

    // per-pair event inputs
    typedef struct packed {
        logic lower_match;
        logic upper_match;
        logic lower_overflow;
        logic lower_timer_input_pin;
    } tpm_events_t;

    // prescaler taps shared by both pairs
    typedef struct packed {
        logic t1;
        logic t4;
        logic t16;
        logic t256;
    } tpm_taps_t;

    // per-pair selections shown to the counters
    typedef struct packed {
        logic       lower_tick;
        logic       upper_tick;
        logic [8:0] pwm_period;
        tpm_mode_t  mode;
    } tpm_pair_sel_t;

endpackage

// ---- rtl/tpm_timer_pair.sv ----
// Purpose: mode, clock select and output flip-flop control, two timer pairs
// Assumes: match, overflow and taps are same-clock pulses; pins are async
// Notes:   counting and run control live elsewhere
//
// Operation
// R01: mode field picks four timer pairings
// R02: lower clock field picks pin or taps
// R03: upper clock picks lower match or taps
// R04: cascaded mode clocks upper on lower overflow
// R05: period codes give 64, 128, 256 cycles
// R06: ff command inverts, sets, clears or holds
// R07: invert enable gates match-driven inversion
// R08: invert source picks lower or upper match
// R09: source choice only in two-timer mode
// R10: second pair has identical own flip-flop
// R11: ff control bits 7..4 read as one
// R12: simultaneous inversions invert only once
// R13: match inversion with set ends at one
// R14: compare registers write-only, reads undefined
// R15: flip-flop drives pair output continuously
`include "tpm_params.svh"
`timescale 1ns/10ps
`default_nettype none

module tpm_timer_pair #(
    parameter int ADDR_W = `TPM_ADDR_W
) (
    input  wire logic                  clock,
    input  wire logic                  srst,
    input  wire logic [ADDR_W-1:0]     reg_addr,
    input  wire logic [7:0]            reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output var  logic [7:0]            reg_rdata,
    input  wire tpm_pkg::tpm_taps_t    taps,
    input  wire tpm_pkg::tpm_events_t  pair_a_events,
    input  wire tpm_pkg::tpm_events_t  pair_b_events,
    output var  tpm_pkg::tpm_pair_sel_t pair_a_sel,
    output var  tpm_pkg::tpm_pair_sel_t pair_b_sel,
    output var  logic [7:0]            pair_a_low_compare,
    output var  logic [7:0]            pair_a_high_compare,
    output var  logic [7:0]            pair_b_low_compare,
    output var  logic [7:0]            pair_b_high_compare,
    output var  logic                  pair_a_out,
    output var  logic                  pair_b_out
);
    import tpm_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // functions

    // lower timer count clock
    function automatic logic lower_tick_f(logic [1:0] sel, logic pin,
                                          tpm_taps_t t);
        logic r;
        r = 1'b0;
        case (sel)
            2'h0:    r = pin;                              // R02
            2'h1:    r = t.t1;
            2'h2:    r = t.t4;
            default: r = t.t16;
        endcase
        return r;
    endfunction

    // upper timer count clock
    function automatic logic upper_tick_f(tpm_mode_cfg_t c, tpm_events_t e,
                                          tpm_taps_t t);
        logic r;
        r = 1'b0;
        if (c.mode == TPM_MODE_CASC16) begin
            r = e.lower_overflow;                          // R04
        end else begin
            case (c.upper_clk)
                2'h0:    r = e.lower_match;                // R03
                2'h1:    r = t.t1;
                2'h2:    r = t.t16;
                default: r = t.t256;
            endcase
        end
        return r;
    endfunction

    // pwm period in clock-source cycles; reserved code kept at 64
    function automatic logic [8:0] period_f(logic [1:0] code);
        logic [8:0] r;
        r = `TPM_PWM_P6;
        case (code)
            2'h2:    r = `TPM_PWM_P7;                      // R05
            2'h3:    r = `TPM_PWM_P8;
            default: r = `TPM_PWM_P6;
        endcase
        return r;
    endfunction

    // next flip-flop state from software command and match inversion
    function automatic logic ff_next_f(logic ff, logic cmd_wr,
                                       tpm_ff_cmd_t cmd, logic match_inv);
        logic r;
        r = match_inv ? ~ff : ff;
        if (cmd_wr) begin
            case (cmd)
                TPM_FF_INVERT: r = ~ff;                    // R12
                TPM_FF_SET:    r = 1'b1;                   // R13
                TPM_FF_CLEAR:  r = 1'b0;
                default:       r = match_inv ? ~ff : ff;
            endcase
        end
        return r;
    endfunction

    // match inversion event for one pair
    function automatic logic match_inv_f(tpm_mode_t m, logic ie, logic is,
                                         tpm_events_t e);
        logic src;
        src = (m == TPM_MODE_TWO8) ? (is ? e.upper_match : e.lower_match)
                                   : e.upper_match;        // R08 R09
        return ie & src;                                   // R07
    endfunction

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers for the external timer inputs

    logic [1:0] pin_a_sync_q;
    logic [1:0] pin_b_sync_q;

    always_ff @(posedge clock) begin
        pin_a_sync_q <= {pin_a_sync_q[0], pair_a_events.lower_timer_input_pin};
        pin_b_sync_q <= {pin_b_sync_q[0], pair_b_events.lower_timer_input_pin};
    end

    ////////////////////////////////////////////////////////////////////
    // register decode

    wire w_a_lo  = reg_wr && reg_addr == `TPM_A_LOW_CMP;
    wire w_a_hi  = reg_wr && reg_addr == `TPM_A_HIGH_CMP;
    wire w_a_md  = reg_wr && reg_addr == `TPM_A_MODE_CFG;
    wire w_a_ff  = reg_wr && reg_addr == `TPM_A_FF_CTRL;
    wire w_b_lo  = reg_wr && reg_addr == `TPM_B_LOW_CMP;
    wire w_b_hi  = reg_wr && reg_addr == `TPM_B_HIGH_CMP;
    wire w_b_md  = reg_wr && reg_addr == `TPM_B_MODE_CFG;
    wire w_b_ff  = reg_wr && reg_addr == `TPM_B_FF_CTRL;

    ////////////////////////////////////////////////////////////////////
    // configuration registers

    tpm_mode_cfg_t mode_a_q;
    tpm_mode_cfg_t mode_b_q;
    logic [1:0]    ffcmd_a_q;
    logic [1:0]    ffcmd_b_q;
    logic          ie_a_q;
    logic          is_a_q;
    logic          ie_b_q;
    logic          is_b_q;
    logic [7:0]    cmp_a_lo_q;
    logic [7:0]    cmp_a_hi_q;
    logic [7:0]    cmp_b_lo_q;
    logic [7:0]    cmp_b_hi_q;

    // compare registers hold reset value until written
    always_ff @(posedge clock) begin
        if (srst) begin
            cmp_a_lo_q <= `TPM_CMP_RESET;                  // R14
            cmp_a_hi_q <= `TPM_CMP_RESET;
            cmp_b_lo_q <= `TPM_CMP_RESET;
            cmp_b_hi_q <= `TPM_CMP_RESET;
        end else begin
            if (w_a_lo) cmp_a_lo_q <= reg_wdata;
            if (w_a_hi) cmp_a_hi_q <= reg_wdata;
            if (w_b_lo) cmp_b_lo_q <= reg_wdata;
            if (w_b_hi) cmp_b_hi_q <= reg_wdata;
        end
    end

    // mode and flip-flop control fields
    always_ff @(posedge clock) begin
        if (srst) begin
            mode_a_q  <= tpm_mode_cfg_t'(`TPM_MODE_RESET);  // R01
            mode_b_q  <= tpm_mode_cfg_t'(`TPM_MODE_RESET);
            ffcmd_a_q <= `TPM_FF_CMD_RESET;
            ffcmd_b_q <= `TPM_FF_CMD_RESET;
            ie_a_q    <= 1'b0;
            is_a_q    <= 1'b0;
            ie_b_q    <= 1'b0;
            is_b_q    <= 1'b0;
        end else begin
            if (w_a_md) mode_a_q <= tpm_mode_cfg_t'(reg_wdata);
            if (w_b_md) mode_b_q <= tpm_mode_cfg_t'(reg_wdata);
            if (w_a_ff) begin
                ffcmd_a_q <= reg_wdata[3:2];
                ie_a_q    <= reg_wdata[1];
                is_a_q    <= reg_wdata[0];
            end
            if (w_b_ff) begin                              // R10
                ffcmd_b_q <= reg_wdata[3:2];
                ie_b_q    <= reg_wdata[1];
                is_b_q    <= reg_wdata[0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // output flip-flops

    wire inv_a = match_inv_f(mode_a_q.mode, ie_a_q, is_a_q, pair_a_events);
    wire inv_b = match_inv_f(mode_b_q.mode, ie_b_q, is_b_q, pair_b_events);
    wire ff_a_d = ff_next_f(pair_a_out, w_a_ff,
                            tpm_ff_cmd_t'(reg_wdata[3:2]), inv_a); // R06
    wire ff_b_d = ff_next_f(pair_b_out, w_b_ff,
                            tpm_ff_cmd_t'(reg_wdata[3:2]), inv_b); // R10

    // flip-flops are the pair outputs themselves
    always_ff @(posedge clock) begin
        if (srst) begin
            pair_a_out <= 1'b0;
            pair_b_out <= 1'b0;
        end else begin
            pair_a_out <= ff_a_d;                          // R15
            pair_b_out <= ff_b_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // selections for the counters, registered

    tpm_pair_sel_t sel_a_d;
    tpm_pair_sel_t sel_b_d;

    assign sel_a_d.lower_tick = lower_tick_f(mode_a_q.lower_clk,
                                             pin_a_sync_q[1], taps);
    assign sel_a_d.upper_tick = upper_tick_f(mode_a_q, pair_a_events, taps);
    assign sel_a_d.pwm_period = period_f(mode_a_q.pwm_period);
    assign sel_a_d.mode       = mode_a_q.mode;
    assign sel_b_d.lower_tick = lower_tick_f(mode_b_q.lower_clk,
                                             pin_b_sync_q[1], taps);
    assign sel_b_d.upper_tick = upper_tick_f(mode_b_q, pair_b_events, taps);
    assign sel_b_d.pwm_period = period_f(mode_b_q.pwm_period);
    assign sel_b_d.mode       = mode_b_q.mode;

    always_ff @(posedge clock) begin
        if (srst) begin
            pair_a_sel <= '0;
            pair_b_sel <= '0;
        end else begin
            pair_a_sel <= sel_a_d;
            pair_b_sel <= sel_b_d;
        end
    end

    // compare values to the counters
    always_ff @(posedge clock) begin
        if (srst) begin
            pair_a_low_compare  <= `TPM_CMP_RESET;
            pair_a_high_compare <= `TPM_CMP_RESET;
            pair_b_low_compare  <= `TPM_CMP_RESET;
            pair_b_high_compare <= `TPM_CMP_RESET;
        end else begin
            pair_a_low_compare  <= cmp_a_lo_q;
            pair_a_high_compare <= cmp_a_hi_q;
            pair_b_low_compare  <= cmp_b_lo_q;
            pair_b_high_compare <= cmp_b_hi_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read mux; compare and unmapped addresses read the undefined value

    logic [7:0] rd_d;

    always_comb begin
        rd_d = `TPM_UNDEF_READ;                            // R14
        case (reg_addr)
            `TPM_A_MODE_CFG: rd_d = mode_a_q;
            `TPM_B_MODE_CFG: rd_d = mode_b_q;
            `TPM_A_FF_CTRL:  rd_d = {`TPM_FF_UNUSED_READ, ffcmd_a_q,
                                     ie_a_q, is_a_q};      // R11
            `TPM_B_FF_CTRL:  rd_d = {`TPM_FF_UNUSED_READ, ffcmd_b_q,
                                     ie_b_q, is_b_q};
            default:         rd_d = `TPM_UNDEF_READ;
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? rd_d : 8'h00;
        end
    end

endmodule

`default_nettype wire

// ---- verification/tpm_timer_pair_checker.sv ----
// Purpose: port-level checks for tpm_timer_pair
// Assumes: one clock, srst synchronous active high
// Notes:   enable, source and mode bits mirrored from writes
`include "tpm_params.svh"
`timescale 1ns/10ps
`default_nettype none
module tpm_timer_pair_checker #(
    parameter int ADDR_W = `TPM_ADDR_W
) (
    input wire logic                   clock,
    input wire logic                   srst,
    input wire logic [ADDR_W-1:0]      reg_addr,
    input wire logic [7:0]             reg_wdata,
    input wire logic                   reg_wr,
    input wire logic                   reg_rd,
    input wire logic [7:0]             reg_rdata,
    input wire tpm_pkg::tpm_events_t   pair_a_events,
    input wire tpm_pkg::tpm_events_t   pair_b_events,
    input wire tpm_pkg::tpm_pair_sel_t pair_b_sel,
    input wire logic                   pair_a_out,
    input wire logic                   pair_b_out
);
    import tpm_pkg::*;
    logic [1:0] ctl_a_q, ctl_b_q, mode_a_q, mode_b_q;
    // write decodes and the selected inversion event per pair
    wire wa = reg_wr && reg_addr == `TPM_A_FF_CTRL;
    wire wb = reg_wr && reg_addr == `TPM_B_FF_CTRL;
    wire hit_a = mode_a_q == 2'h0 && !ctl_a_q[0] ? pair_a_events.lower_match
                                                 : pair_a_events.upper_match;
    wire hit_b = mode_b_q == 2'h0 && !ctl_b_q[0] ? pair_b_events.lower_match
                                                 : pair_b_events.upper_match;
    // mirror of enable, source and mode fields
    always_ff @(posedge clock) begin
        if (srst) begin
            {ctl_a_q, ctl_b_q, mode_a_q, mode_b_q} <= 8'h00;
        end else begin
            if (wa) ctl_a_q <= reg_wdata[1:0];
            if (wb) ctl_b_q <= reg_wdata[1:0];
            if (reg_wr && reg_addr == `TPM_A_MODE_CFG)
                mode_a_q <= reg_wdata[7:6];
            if (reg_wr && reg_addr == `TPM_B_MODE_CFG)
                mode_b_q <= reg_wdata[7:6];
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////////
    AST_CMP_READ: assert property (
        reg_rd && reg_addr == `TPM_A_LOW_CMP |=> reg_rdata == 8'h00)
        else $error("compare read not zero");
    AST_FF_UNUSED: assert property (
        reg_rd && reg_addr == `TPM_B_FF_CTRL |=> reg_rdata[7:4] == 4'hf)
        else $error("ff control upper bits not one");
    AST_A_SET: assert property (
        wa && reg_wdata[3:2] == 2'h1 |=> pair_a_out)
        else $error("set command missed");
    AST_A_CLEAR: assert property (
        wa && reg_wdata[3:2] == 2'h2 |=> !pair_a_out)
        else $error("clear command missed");
    AST_A_INVERT: assert property (
        wa && reg_wdata[3:2] == 2'h0 |=> pair_a_out != $past(pair_a_out))
        else $error("software invert wrong");
    AST_A_QUIET: assert property (
        !wa && !(ctl_a_q[1] && hit_a) |=> $stable(pair_a_out))
        else $error("pair a output moved without cause");
    AST_A_MATCH: assert property (
        !wa && ctl_a_q[1] && hit_a |=> pair_a_out != $past(pair_a_out))
        else $error("pair a match inversion missed");
    AST_B_SET: assert property (
        wb && reg_wdata[3:2] == 2'h1 |=> pair_b_out)
        else $error("pair b set missed");
    AST_B_MATCH: assert property (
        !wb && ctl_b_q[1] && hit_b |=> pair_b_out != $past(pair_b_out))
        else $error("pair b match inversion missed");
    AST_CASC: assert property (
        mode_b_q == 2'h1 && pair_b_events.lower_overflow
        |=> pair_b_sel.upper_tick)
        else $error("cascade tick missed");
    AST_PWM: assert property (
        reg_wr && reg_addr == `TPM_B_MODE_CFG && reg_wdata[5:4] == 2'h3
        |-> ##2 pair_b_sel.pwm_period == `TPM_PWM_P8)
        else $error("pwm period wrong");
    // main scenarios
    COV_MATCH: cover property (ctl_a_q[1] && hit_a);
    COV_COLLIDE: cover property (wa && pair_a_events.lower_match);
    COV_CASC: cover property (mode_b_q == 2'h1 && pair_b_events.lower_overflow);
endmodule
bind tpm_timer_pair tpm_timer_pair_checker #(.ADDR_W(ADDR_W))
    tpm_timer_pair_checker_inst (.clock(clock), .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pair_a_events(pair_a_events),
    .pair_b_events(pair_b_events), .pair_b_sel(pair_b_sel),
    .pair_a_out(pair_a_out), .pair_b_out(pair_b_out));
`default_nettype wire

// ---- verification/tpm_timer_pair_tb.sv ----
// Purpose: directed bench for tpm_timer_pair
// Assumes: 10 MHz clock, srst synchronous active high
// Notes:   outputs sampled 1 ns after the edge that updates them
`include "tpm_params.svh"
`timescale 1ns/10ps
`default_nettype none
module tpm_timer_pair_tb;
    import tpm_pkg::*;
    logic          clock = 1'b0;
    logic          srst = 1'b1;
    logic [8:0]    reg_addr = 9'h000;
    logic [7:0]    reg_wdata = 8'h00;
    logic          reg_wr = 1'b0;
    logic          reg_rd = 1'b0;
    logic [7:0]    reg_rdata, cmp [4];
    tpm_taps_t     taps = 4'h0;
    tpm_events_t   ev_a = 4'h0;
    tpm_events_t   ev_b = 4'h0;
    tpm_pair_sel_t sel_a, sel_b;
    logic          out_a, out_b;
    int            failures = 0;
    int            checks = 0;
    tpm_timer_pair tpm_timer_pair_inst (.clock(clock), .srst(srst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .taps(taps),
        .pair_a_events(ev_a), .pair_b_events(ev_b), .pair_a_sel(sel_a),
        .pair_b_sel(sel_b), .pair_a_low_compare(cmp[0]),
        .pair_a_high_compare(cmp[1]), .pair_b_low_compare(cmp[2]),
        .pair_b_high_compare(cmp[3]), .pair_a_out(out_a), .pair_b_out(out_b));
    // clock source
    initial begin
        forever #50 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // compare and count
    task automatic chk(input string n, input logic [8:0] e,
                       input logic [8:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask
    function automatic logic op(input int p);
        return p ? out_b : out_a;
    endfunction
    // one bus cycle with taps and events beside it
    task automatic cyc(input logic w, input logic [8:0] a, input logic [7:0] d,
                       input logic [3:0] t, ea, eb);
        @(posedge clock);
        reg_wr <= w;
        reg_addr <= a;
        reg_wdata <= d;
        taps <= t;
        ev_a <= ea;
        ev_b <= eb;
        @(posedge clock);
        reg_wr <= 1'b0;
        taps <= 4'h0;
        ev_a <= 4'h0;
        ev_b <= 4'h0;
        #1;
    endtask
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        cyc(1'b1, a, d, 4'h0, 4'h0, 4'h0);
    endtask
    task automatic rdc(input logic [8:0] a, input logic [7:0] e);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rdata", {1'b0, e}, {1'b0, reg_rdata});
    endtask
    // one match event after setting mode and ff control
    task automatic m(input int p, input logic [7:0] md, c, input logic [3:0] e,
                     input logic tg);
        logic was;
        wr(p ? `TPM_B_MODE_CFG : `TPM_A_MODE_CFG, md);
        wr(p ? `TPM_B_FF_CTRL : `TPM_A_FF_CTRL, c);
        was = op(p);
        cyc(1'b0, 9'h0, 8'h0, 4'h0, p ? 4'h0 : e, p ? e : 4'h0);
        chk("match out", {8'h0, was ^ tg}, {8'h0, op(p)});
    endtask
    // one source pulse on pair b, then its tick
    task automatic tk(input logic up, input logic [3:0] t, e, input logic x);
        cyc(1'b0, 9'h0, 8'h0, t, 4'h0, e);
        chk("tick", {8'h0, x},
            {8'h0, up ? sel_b.upper_tick : sel_b.lower_tick});
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic s_reset();
        rdc(`TPM_A_FF_CTRL, 8'hfc);
        rdc(`TPM_B_FF_CTRL, 8'hfc);
        rdc(`TPM_A_LOW_CMP, 8'h00);
        rdc(9'h1ff, 8'h00);
        for (int i = 0; i < 4; i++) chk("compare", 9'h0, {1'b0, cmp[i]});
    endtask
    task automatic s_cmds();
        logic [8:0] a;
        for (int p = 0; p < 2; p++) begin
            a = p ? `TPM_B_FF_CTRL : `TPM_A_FF_CTRL;
            wr(a, 8'h04);
            chk("ff set", 9'h1, {8'h0, op(p)});
            wr(a, 8'h08);
            chk("ff clear", 9'h0, {8'h0, op(p)});
            wr(a, 8'h00);
            chk("ff invert", 9'h1, {8'h0, op(p)});
            wr(a, 8'h0c);
            chk("ff hold", 9'h1, {8'h0, op(p)});
        end
        wr(`TPM_A_FF_CTRL, 8'h08);
        chk("pair b kept", 9'h1, {8'h0, out_b});
    endtask
    task automatic s_match();
        m(0, 8'h10, 8'h0e, 4'h8, 1'b1);
        m(0, 8'h10, 8'h0e, 4'h4, 1'b0);
        m(0, 8'h10, 8'h0f, 4'h4, 1'b1);
        m(0, 8'h10, 8'h0f, 4'h8, 1'b0);
        m(0, 8'h10, 8'h0c, 4'hc, 1'b0);
        m(0, 8'h50, 8'h0e, 4'h8, 1'b0);
        m(0, 8'h50, 8'h0e, 4'h4, 1'b1);
        m(1, 8'h10, 8'h0f, 4'h4, 1'b1);
        m(1, 8'h10, 8'h0c, 4'h8, 1'b0);
        wr(`TPM_A_MODE_CFG, 8'h10);
        wr(`TPM_A_FF_CTRL, 8'h0a);
        cyc(1'b1, `TPM_A_FF_CTRL, 8'h02, 4'h0, 4'h8, 4'h0);
        chk("invert once", 9'h1, {8'h0, out_a});
        cyc(1'b1, `TPM_A_FF_CTRL, 8'h06, 4'h0, 4'h8, 4'h0);
        chk("set wins", 9'h1, {8'h0, out_a});
    endtask
    task automatic s_clock();
        logic [3:0] t, u;
        int n;
        for (int c = 1; c < 4; c++) begin
            t = 4'h8 >> (c - 1);
            u = (c == 1) ? 4'h8 : (c == 2) ? 4'h2 : 4'h1;
            wr(`TPM_B_MODE_CFG, {6'h04, c[1:0]});
            tk(1'b0, t, 4'h0, 1'b1);
            tk(1'b0, ~t, 4'h8, 1'b0);
            wr(`TPM_B_MODE_CFG, {4'h1, c[1:0], 2'h1});
            tk(1'b1, u, 4'h0, 1'b1);
            tk(1'b1, ~u, 4'h8, 1'b0);
        end
        wr(`TPM_B_MODE_CFG, 8'h10);
        tk(1'b1, 4'h0, 4'h8, 1'b1);
        tk(1'b1, 4'hf, 4'h6, 1'b0);
        tk(1'b0, 4'hf, 4'h0, 1'b0);
        @(posedge clock);
        ev_b <= 4'h1;
        for (n = 0; n < 6 && sel_b.lower_tick !== 1'b1; n++) @(posedge clock);
        ev_b <= 4'h0;
        chk("pin tick", 9'h1, {8'h0, sel_b.lower_tick});
        if (n == 6) complete_run();
        wr(`TPM_B_MODE_CFG, 8'h54);
        tk(1'b1, 4'h8, 4'h0, 1'b0);
        tk(1'b1, 4'h0, 4'h2, 1'b1);
        for (int md = 0; md < 4; md++) begin
            for (int p = 1; p < 4; p++) begin
                wr(`TPM_B_MODE_CFG, {md[1:0], p[1:0], 4'h0});
                rdc(`TPM_B_MODE_CFG, {md[1:0], p[1:0], 4'h0});
                chk("mode", {7'h0, md[1:0]}, {7'h0, sel_b.mode});
                chk("period", 9'h020 << p, sel_b.pwm_period);
            end
        end
    endtask
    // pair a selections: cascade, lower clock on the t4 tap, longest period
    task automatic s_pair_a();
        wr(`TPM_A_MODE_CFG, 8'h76);
        cyc(1'b0, 9'h0, 8'h0, 4'h4, 4'h2, 4'h0);
        chk("a lower tick", 9'h1, {8'h0, sel_a.lower_tick});
        chk("a upper tick", 9'h1, {8'h0, sel_a.upper_tick});
        chk("a mode", 9'h1, {7'h0, sel_a.mode});
        chk("a period", `TPM_PWM_P8, sel_a.pwm_period);
    endtask
    task automatic s_cmp();
        logic [8:0] a;
        for (int i = 0; i < 4; i++) begin
            a = 9'h102 | {4'h0, i[1], 3'h0, i[0]};
            wr(a, 8'h5a ^ i[7:0]);
            rdc(a, 8'h00);
            chk("compare", {1'b0, 8'h5a ^ i[7:0]}, {1'b0, cmp[i]});
        end
    endtask
    // main sequence
    initial begin
        repeat (8) @(posedge clock);
        srst <= 1'b0;
        s_reset();
        s_cmds();
        s_match();
        s_pair_a();
        s_clock();
        s_cmp();
        complete_run();
    end
endmodule
`default_nettype wire
